//--- rtl/adc_start_pkg.sv
// Constants, types and helpers for the conversion start control.
// Assumes a single 40 MHz system clock; conversion and acquisition times are converted here.
package adc_start_pkg;

    localparam int CLK_SYS_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;

    // Control register layout, most significant bit shifted first
    localparam int CTRL_BITS = 5;
    localparam int CHAN_W = 3;
    localparam int FLD_CHAN_MSB = 4;
    localparam int FLD_CHAN_LSB = 2;
    localparam int FLD_SOFT_START = 1;
    localparam int FLD_POWERDOWN = 0;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [3:0] LOAD_EDGE = 4'h6;
    localparam logic [3:0] POWERDOWN_BIT_EDGE = 4'h7;
    localparam logic [3:0] EDGE_MAX = 4'hF;

    // Conversion timing
    localparam int RESULT_W = 12;
    localparam int CODE_SPAN = 4096;
    localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
    localparam logic [4:0] SOFT_START_BIT_MCLK_HALF_EDGES = 5'h1D;
    localparam int SOFT_START_BIT_MAX_NS = 5900;
    localparam int SOFT_START_BIT_MAX_CYCLES = SOFT_START_BIT_MAX_NS / CLK_PERIOD_NS;
    localparam int ACQ_NS = 2000;
    localparam int ACQ_CYCLES = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET_NS = 500;

    // Throughput limits
    localparam int THRU_EXT_HZ = 117_000;
    localparam int THRU_EXT_DEGRADED_HZ = 127_000;
    localparam int THRU_SELF_HZ = 78_000;
    localparam int THRU_W = 10;

    // Synchroniser bit positions
    localparam int SYNC_W = 6;
    localparam int SY_SCLK = 0;
    localparam int SY_FRAME_N = 1;
    localparam int SY_SDATA = 2;
    localparam int SY_TRIG = 3;
    localparam int SY_MCLK = 4;
    localparam int SY_SMODE = 5;

    typedef enum logic [1:0] {
        SOFT_START_BIT_IDLE = 2'b00,
        SOFT_START_BIT_RUN = 2'b01,
        SOFT_START_BIT_ACQ = 2'b11
    } soft_start_bit_state_e;

    // Least start-to-start spacing, rounded up to whole cycles
    function automatic logic [THRU_W-1:0] period_cycles(input int rateHz);
        period_cycles = THRU_W'((CLK_SYS_HZ + rateHz - 1) / rateHz);
    endfunction : period_cycles

    // Straight binary from the core, twos complement for the bipolar range
    function automatic logic [11:0] to_output_code(input logic bipolar,
                                                   input logic [11:0] raw);
        to_output_code = bipolar ? (raw ^ BIPOLAR_FLIP) : raw;
    endfunction : to_output_code

endpackage : adc_start_pkg

//--- rtl/settle_if.sv
// Carrier between the sequencer and the settling timer.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface settle_if;
    logic launch;
    logic arm;
    logic cancel;
    logic busy;
    logic done;
    logic nodeHigh;

    modport ctrl (output launch, output arm, output cancel,
                  input busy, input done, input nodeHigh);
    modport timer (input launch, input arm, input cancel,
                   output busy, output done, output nodeHigh);
endinterface : settle_if

//--- rtl/sync2.sv
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes inputs are quasi-static relative to clk_sys.
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= INIT;
            syncOut <= INIT;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : sync2

//--- rtl/settle_timer.sv
// Settling pulse model: node low from write start, times out after arm.
// Assumes the capacitor time is given as a count of clk_sys cycles.
`timescale 1ns/100ps
module settle_timer #(
    parameter int SETTLE_CYCLES = 400
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    settle_if.timer st
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

    logic [CW-1:0] count_q;
    logic counting_q;

    // Node level and busy flag
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st.busy <= 1'b0;
            st.nodeHigh <= 1'b1;
            counting_q <= 1'b0;
        end else if (st.launch) begin
            st.busy <= 1'b1;
            st.nodeHigh <= 1'b0;
            counting_q <= 1'b0;
        end else if (st.arm) begin
            st.busy <= 1'b1;
            counting_q <= 1'b1;
        end else if (st.cancel) begin
            st.busy <= 1'b0;
            st.nodeHigh <= 1'b1;
            counting_q <= 1'b0;
        end else if (counting_q && count_q == LAST) begin
            st.busy <= 1'b0;
            st.nodeHigh <= 1'b1;
            counting_q <= 1'b0;
        end
    end

    // Discharge counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (st.launch || st.arm) begin
            count_q <= '0;
        end else if (counting_q) begin
            count_q <= count_q + CW'(1);
        end
    end

    // One-cycle strobe when the threshold is crossed
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st.done <= 1'b0;
        end else begin
            st.done <= counting_q && count_q == LAST && !st.launch && !st.arm
                       && !st.cancel;
        end
    end
endmodule : settle_timer

//--- rtl/adc_conversion_start_control.sv
// Conversion start sequencing for an eight-channel 12-bit sampling converter.
// Assumes serial pins, trigger and master clock arrive asynchronously.
`timescale 1ns/100ps
module adc_conversion_start_control
    import adc_start_pkg::*;
#(
    parameter logic BIPOLAR = 1'b0,
    parameter int SETTLE_CYCLES = 400
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic writeFrameN,
    input wire logic serialDataIn,
    input wire logic sampleTrigger,
    input wire logic masterClkIn,
    input wire logic selfClockMode,
    input wire logic degradedRateEn,
    input wire logic [11:0] rawSampleCode,
    output logic trackHold,
    output logic convBusy,
    output logic [11:0] resultData,
    output logic resultValid,
    output logic [2:0] chanSel,
    output logic softStartBit,
    output logic powerdownBit,
    output logic settleTimerNode
);
    localparam int SOFT_START_BIT_CW = 8;
    localparam logic [SOFT_START_BIT_CW-1:0] SOFT_START_BIT_LAST = SOFT_START_BIT_CW'(SOFT_START_BIT_MAX_CYCLES - 1);
    localparam logic [SOFT_START_BIT_CW-1:0] ACQ_LAST = SOFT_START_BIT_CW'(ACQ_CYCLES - 1);
    localparam logic [THRU_W-1:0] THRU_EXT = period_cycles(THRU_EXT_HZ);
    localparam logic [THRU_W-1:0] THRU_EXT_DEG = period_cycles(THRU_EXT_DEGRADED_HZ);
    localparam logic [THRU_W-1:0] THRU_SELF = period_cycles(THRU_SELF_HZ);
    // Pin idle levels, so no false frame edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = (SYNC_W'(1) << SY_FRAME_N)
                                              | (SYNC_W'(1) << SY_SCLK);

    settle_if st ();

    logic [SYNC_W-1:0] pinSync;
    logic sclk_q;
    logic frameN_q;
    logic trig_q;
    logic mclk_q;
    logic sclkFall;
    logic frameStart;
    logic frameEnd;
    logic trigRise;
    logic mclkEdge;

    logic [3:0] edgeCount_q;
    logic [CTRL_BITS-1:0] shift_q;
    logic [CTRL_BITS-1:0] shift_d;
    logic softPending_q;
    logic softLoad;
    logic shortSoft;

    soft_start_bit_state_e state_q;
    logic [SOFT_START_BIT_CW-1:0] cycleCount_q;
    logic [4:0] mclkCount_q;
    logic [11:0] heldCode_q;
    logic [THRU_W-1:0] thruCount_q;
    logic [THRU_W-1:0] thruLimit;
    logic canStart;
    logic hwStart;
    logic swStart;
    logic convDone;

    sync2 #(
        .W(SYNC_W),
        .INIT(SYNC_IDLE)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .asyncIn({selfClockMode, masterClkIn, sampleTrigger,
                  serialDataIn, writeFrameN, serialClk}),
        .syncOut(pinSync)
    );

    settle_timer #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_settle (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .st(st)
    );

    // Edge history of synchronised pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sclk_q <= 1'b0;
            frameN_q <= 1'b1;
            trig_q <= 1'b0;
            mclk_q <= 1'b0;
        end else begin
            sclk_q <= pinSync[SY_SCLK];
            frameN_q <= pinSync[SY_FRAME_N];
            trig_q <= pinSync[SY_TRIG];
            mclk_q <= pinSync[SY_MCLK];
        end
    end

    assign sclkFall = sclk_q && !pinSync[SY_SCLK] && !pinSync[SY_FRAME_N];
    assign frameStart = frameN_q && !pinSync[SY_FRAME_N];
    assign frameEnd = !frameN_q && pinSync[SY_FRAME_N];
    assign trigRise = !trig_q && pinSync[SY_TRIG];
    assign mclkEdge = mclk_q ^ pinSync[SY_MCLK];
    assign shift_d = {shift_q[CTRL_BITS-2:0], pinSync[SY_SDATA]};

    // Address and start bits load on the sixth edge
    assign softLoad = sclkFall && edgeCount_q == LOAD_EDGE - 4'h1
                      && shift_q[FLD_SOFT_START];
    // Short write with start bit already set still starts
    assign shortSoft = frameEnd && edgeCount_q < LOAD_EDGE && softStartBit;

    // Settling pulse control
    assign st.launch = frameStart;
    assign st.arm = (sclkFall && edgeCount_q == LOAD_EDGE - 4'h1)
                    || shortSoft;
    assign st.cancel = frameEnd && edgeCount_q < LOAD_EDGE && !softStartBit;

    // Falling edge counter within a write frame
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            edgeCount_q <= 4'h0;
        end else if (frameStart) begin
            edgeCount_q <= 4'h0;
        end else if (sclkFall && edgeCount_q != EDGE_MAX) begin
            edgeCount_q <= edgeCount_q + 4'h1;
        end
    end

    // Serial shift register, first bit ends up most significant
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= CTRL_RESET;
        end else if (sclkFall && edgeCount_q < CTRL_BITS[3:0]) begin
            shift_q <= shift_d;
        end
    end

    // Control register: address and start at edge six, standby at seven
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            chanSel <= CTRL_RESET[FLD_CHAN_MSB:FLD_CHAN_LSB];
            softStartBit <= CTRL_RESET[FLD_SOFT_START];
            powerdownBit <= CTRL_RESET[FLD_POWERDOWN];
        end else if (sclkFall && edgeCount_q == LOAD_EDGE - 4'h1) begin
            chanSel <= shift_q[FLD_CHAN_MSB:FLD_CHAN_LSB];
            softStartBit <= shift_q[FLD_SOFT_START];
        end else if (sclkFall && edgeCount_q == POWERDOWN_BIT_EDGE - 4'h1) begin
            powerdownBit <= shift_q[FLD_POWERDOWN];
        end
    end

    // Pending software start; a new request beats the clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            softPending_q <= 1'b0;
        end else if (softLoad || shortSoft) begin
            softPending_q <= 1'b1;
        end else if (swStart) begin
            softPending_q <= 1'b0;
        end else if (sclkFall && edgeCount_q == LOAD_EDGE - 4'h1) begin
            softPending_q <= 1'b0;
        end
    end

    // Throughput spacing per clocking mode
    always_comb begin
        if (pinSync[SY_SMODE]) begin
            thruLimit = THRU_SELF;
        end else if (degradedRateEn) begin
            thruLimit = THRU_EXT_DEG;
        end else begin
            thruLimit = THRU_EXT;
        end
    end

    // Start qualification
    assign canStart = state_q == SOFT_START_BIT_IDLE && !st.busy && thruCount_q == '0
                      && !powerdownBit;
    assign hwStart = trigRise && !softStartBit && canStart
                     && !softPending_q;
    assign swStart = softPending_q && canStart && !st.launch;

    assign convDone = state_q == SOFT_START_BIT_RUN
                      && (mclkCount_q == SOFT_START_BIT_MCLK_HALF_EDGES
                          || cycleCount_q == SOFT_START_BIT_LAST);

    // Conversion sequencer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SOFT_START_BIT_IDLE;
        end else begin
            unique case (state_q)
                SOFT_START_BIT_IDLE: begin
                    if (hwStart || swStart) begin
                        state_q <= SOFT_START_BIT_RUN;
                    end
                end
                SOFT_START_BIT_RUN: begin
                    if (convDone) begin
                        state_q <= SOFT_START_BIT_ACQ;
                    end
                end
                SOFT_START_BIT_ACQ: begin
                    if (cycleCount_q == ACQ_LAST) begin
                        state_q <= SOFT_START_BIT_IDLE;
                    end
                end
                default: begin
                    state_q <= SOFT_START_BIT_IDLE;
                end
            endcase
        end
    end

    // Cycle and master clock counters
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cycleCount_q <= '0;
            mclkCount_q <= 5'h00;
        end else if (hwStart || swStart || convDone) begin
            cycleCount_q <= '0;
            mclkCount_q <= 5'h00;
        end else if (state_q != SOFT_START_BIT_IDLE) begin
            cycleCount_q <= cycleCount_q + SOFT_START_BIT_CW'(1);
            if (mclkEdge && mclkCount_q != SOFT_START_BIT_MCLK_HALF_EDGES) begin
                mclkCount_q <= mclkCount_q + 5'h01;
            end
        end
    end

    // Start-to-start spacing counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            thruCount_q <= '0;
        end else if (hwStart || swStart) begin
            thruCount_q <= thruLimit - THRU_W'(1);
        end else if (thruCount_q != '0) begin
            thruCount_q <= thruCount_q - THRU_W'(1);
        end
    end

    // Track/hold and busy
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trackHold <= 1'b0;
            convBusy <= 1'b0;
        end else if (hwStart || swStart) begin
            trackHold <= 1'b1;
            convBusy <= 1'b1;
        end else if (convDone) begin
            trackHold <= 1'b0;
            convBusy <= 1'b0;
        end
    end

    // Sample capture at hold entry
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            heldCode_q <= 12'h000;
        end else if (hwStart || swStart) begin
            heldCode_q <= rawSampleCode;
        end
    end

    // Result word and valid strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resultData <= 12'h000;
            resultValid <= 1'b0;
        end else begin
            resultValid <= convDone;
            if (convDone) begin
                resultData <= to_output_code(BIPOLAR, heldCode_q);
            end
        end
    end

    // Settling node level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            settleTimerNode <= 1'b1;
        end else begin
            settleTimerNode <= st.nodeHigh;
        end
    end

endmodule : adc_conversion_start_control

//--- dv/adc_start_assertions.sv
// Port-level checker for the conversion start control.
// Assumes it is bound onto adc_conversion_start_control, one clk_sys domain.
`timescale 1ns/100ps
module adc_start_assertions #(
    parameter logic BIPOLAR = 1'b0,
    parameter int SETTLE_CYCLES = 400
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [11:0] rawSampleCode,
    input wire logic trackHold,
    input wire logic convBusy,
    input wire logic [11:0] resultData,
    input wire logic resultValid,
    input wire logic powerdownBit,
    input wire logic settleTimerNode
);
    localparam int SOFT_START_BIT_LIM = 237;
    localparam int ACQ_MIN = 80;
    localparam int GAP_MIN = 315;
    logic [9:0] sinceEnd_q;
    logic [9:0] sinceStart_q;
    logic [8:0] highCnt_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Cycles since hold ended, since hold began, and hold length
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) sinceEnd_q <= 10'h3FF;
        else if (trackHold) sinceEnd_q <= 10'h000;
        else if (sinceEnd_q != 10'h3FF) sinceEnd_q <= sinceEnd_q + 10'h001;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) sinceStart_q <= 10'h3FF;
        else if ($rose(trackHold)) sinceStart_q <= 10'h001;
        else if (sinceStart_q != 10'h3FF) sinceStart_q <= sinceStart_q + 10'h001;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) highCnt_q <= 9'h000;
        else if (!trackHold) highCnt_q <= 9'h000;
        else if (highCnt_q != 9'h1FF) highCnt_q <= highCnt_q + 9'h001;
    end

    sequence settling_s;
        !trackHold && !settleTimerNode ##1 !settleTimerNode;
    endsequence
    sequence soft_start_bit_end_s;
        $fell(trackHold);
    endsequence

    no_hold_settling_a: assert property (settling_s |-> !trackHold)
        else $error("hold entered while settling");
    busy_hold_pair_a: assert property (convBusy == trackHold)
        else $error("busy and hold differ");
    soft_start_bit_time_cap_a: assert property (highCnt_q <= SOFT_START_BIT_LIM)
        else $error("conversion too long");
    result_on_end_a: assert property (soft_start_bit_end_s |-> ##[0:1] resultValid)
        else $error("no result after conversion");
    valid_one_cycle_a: assert property (resultValid |=> !resultValid)
        else $error("result valid longer than one cycle");
    result_hold_a: assert property (!resultValid |-> $stable(resultData))
        else $error("result changed without valid");
    code_format_a: assert property (resultValid |->
        resultData == (BIPOLAR ? (rawSampleCode ^ 12'h800) : rawSampleCode))
        else $error("result code format wrong");
    reacquire_gap_a: assert property ($rose(trackHold) |-> sinceEnd_q >= ACQ_MIN)
        else $error("start during reacquire");
    start_spacing_a: assert property ($rose(trackHold) |-> sinceStart_q >= GAP_MIN)
        else $error("starts too close");
    standby_block_a: assert property (powerdownBit |-> !$rose(trackHold))
        else $error("start in standby");
endmodule : adc_start_assertions

bind adc_conversion_start_control adc_start_assertions #(
    .BIPOLAR(BIPOLAR),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) i_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .rawSampleCode(rawSampleCode),
    .trackHold(trackHold), .convBusy(convBusy), .resultData(resultData),
    .resultValid(resultValid), .powerdownBit(powerdownBit),
    .settleTimerNode(settleTimerNode)
);

//--- dv/host_port_model.sv
// Host serial port model: control writes and trigger pulses.
// Assumes clk_sys paces every pin change, four cycles per level.
`timescale 1ns/100ps
module host_port_model (
    input wire logic clk_sys,
    output logic serialClk,
    output logic writeFrameN,
    output logic serialDataIn,
    output logic sampleTrigger
);
    initial begin
        serialClk = 1'b1;
        writeFrameN = 1'b1;
        serialDataIn = 1'b0;
        sampleTrigger = 1'b0;
    end

    // Frame with a given count of falling edges, MSB first
    task automatic write_ctrl(input logic [4:0] val, input int edges);
        int i;
        @(posedge clk_sys);
        writeFrameN <= 1'b0;
        for (i = 0; i < edges; i++) begin
            serialDataIn <= (i < 5) ? val[4-i] : 1'b0;
            repeat (4) @(posedge clk_sys);
            serialClk <= 1'b0;
            repeat (4) @(posedge clk_sys);
            serialClk <= 1'b1;
        end
        repeat (4) @(posedge clk_sys);
        writeFrameN <= 1'b1;
        serialDataIn <= ~serialDataIn;
        repeat (4) @(posedge clk_sys);
    endtask : write_ctrl

    task automatic pulse_trig();
        @(posedge clk_sys);
        sampleTrigger <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sampleTrigger <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : pulse_trig
endmodule : host_port_model

//--- dv/test_adc_conversion_start_control.sv
// Self-checking bench for the conversion start control.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
module test_adc_conversion_start_control;
    localparam int SC = 40;
    logic clk_sys, reset_n, masterClkIn, selfClockMode, degradedRateEn;
    logic serialClk, writeFrameN, serialDataIn, sampleTrigger;
    logic trackHold, convBusy, resultValid, softStartBit, powerdownBit, settleTimerNode;
    logic [11:0] rawSampleCode;
    logic [11:0] resultData;
    logic [11:0] bipolarResult;
    logic [2:0] chanSel;
    logic [2:0] mclkDiv;
    int num_errors = 0;
    int n_checks = 0;
    int n;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Master clock at 5 MHz
    always @(posedge clk_sys) mclkDiv <= mclkDiv + 3'h1;
    assign masterClkIn = mclkDiv[2];

    adc_conversion_start_control #(.BIPOLAR(1'b0), .SETTLE_CYCLES(SC)) i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .serialClk(serialClk),
        .writeFrameN(writeFrameN), .serialDataIn(serialDataIn),
        .sampleTrigger(sampleTrigger), .masterClkIn(masterClkIn),
        .selfClockMode(selfClockMode), .degradedRateEn(degradedRateEn),
        .rawSampleCode(rawSampleCode), .trackHold(trackHold), .convBusy(convBusy),
        .resultData(resultData), .resultValid(resultValid), .chanSel(chanSel),
        .softStartBit(softStartBit), .powerdownBit(powerdownBit),
        .settleTimerNode(settleTimerNode));
    host_port_model i_host (.clk_sys(clk_sys), .serialClk(serialClk),
        .writeFrameN(writeFrameN), .serialDataIn(serialDataIn),
        .sampleTrigger(sampleTrigger));
    // Bipolar variant on the same stimulus
    adc_conversion_start_control #(.BIPOLAR(1'b1), .SETTLE_CYCLES(SC)) i_dut_bip (
        .clk_sys(clk_sys), .reset_n(reset_n), .serialClk(serialClk),
        .writeFrameN(writeFrameN), .serialDataIn(serialDataIn),
        .sampleTrigger(sampleTrigger), .masterClkIn(masterClkIn),
        .selfClockMode(selfClockMode), .degradedRateEn(degradedRateEn),
        .rawSampleCode(rawSampleCode), .trackHold(), .convBusy(),
        .resultData(bipolarResult), .resultValid(), .chanSel(),
        .softStartBit(), .powerdownBit(), .settleTimerNode());

    task automatic note(input logic bad, input string msg);
        n_checks++;
        if (bad) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : note
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string msg);
        note(got !== exp, msg);
    endtask : chk_val
    task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
        note(got < lo || got > hi, msg);
    endtask : chk_rng

    function automatic logic sig(input int sel);
        return (sel == 0) ? trackHold : (sel == 1) ? settleTimerNode : resultValid;
    endfunction : sig
    // Bounded wait for a level; cnt equals lim on timeout
    task automatic wait_sig(input int sel, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (sig(sel) !== lvl && cnt < lim) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
    endtask : wait_sig
    task automatic do_write(input logic [4:0] val, input int edges, output int lowAt);
        fork
            i_host.write_ctrl(val, edges);
            wait_sig(1, 1'b0, 12, lowAt);
        join
    endtask : do_write
    task automatic trig_wait(input int lim, output int cnt);
        fork
            i_host.pulse_trig();
            wait_sig(0, 1'b1, lim, cnt);
        join
    endtask : trig_wait

    task automatic t_reset();
        chk_val(12'(chanSel), 12'h000, "channel reset");
        chk_val(12'({softStartBit, powerdownBit}), 12'h000, "control reset");
        chk_val(12'({trackHold, settleTimerNode}), 12'h001, "idle levels");
    endtask : t_reset

    task automatic t_load();
        do_write(5'b10100, 6, n);
        chk_rng(n, 1, 8, "pulse starts with write");
        chk_val(12'({chanSel, settleTimerNode}), 12'h00A, "address loaded");
        wait_sig(1, 1'b1, SC + 40, n);
        chk_rng(n, SC - 16, SC - 6, "pulse times out from sixth edge");
    endtask : t_load

    task automatic t_blocked();
        fork
            do_write(5'b01000, 6, n);
            begin
                repeat (10) @(posedge clk_sys);
                i_host.pulse_trig();
            end
        join
        wait_sig(1, 1'b1, SC + 40, n);
        chk_val(12'(trackHold), 12'h000, "trigger ignored while settling");
        repeat (20) @(posedge clk_sys);
    endtask : t_blocked

    task automatic t_hw(input logic [11:0] raw);
        @(posedge clk_sys);
        rawSampleCode <= raw;
        trig_wait(8, n);
        chk_rng(n, 2, 6, "hold on trigger edge");
        chk_val(12'(convBusy), 12'h001, "busy with hold");
        wait_sig(0, 1'b0, 250, n);
        chk_rng(n, 105, 125, "paced by master clock");
        wait_sig(2, 1'b1, 2, n);
        chk_rng(n, 0, 1, "valid with conversion end");
        chk_val(resultData, raw, "straight binary result");
        chk_val(bipolarResult, raw ^ 12'h800, "twos complement result");
        trig_wait(20, n);
        chk_rng(n, 20, 20, "no start while reacquiring");
        repeat (400) @(posedge clk_sys);
    endtask : t_hw

    // Second trigger 330 cycles after the first
    task automatic t_gap(input logic self, input logic deg, input int lo, input int hi);
        @(posedge clk_sys);
        selfClockMode <= self;
        degradedRateEn <= deg;
        i_host.pulse_trig();
        repeat (321) @(posedge clk_sys);
        trig_wait(10, n);
        chk_rng(n, lo, hi, "start spacing limit");
        repeat (400) @(posedge clk_sys);
        selfClockMode <= 1'b0;
    endtask : t_gap

    task automatic t_soft();
        int hiAt;
        do_write(5'b01110, 6, n);
        chk_val(12'({chanSel, softStartBit}), 12'h007, "start bit loaded");
        fork
            wait_sig(1, 1'b1, SC + 20, hiAt);
            wait_sig(0, 1'b1, SC + 20, n);
        join
        chk_rng(n, 1, SC + 19, "soft start happened");
        chk_rng(n - hiAt, 0, 2, "soft start after pulse");
        repeat (400) @(posedge clk_sys);
        trig_wait(20, n);
        chk_rng(n, 20, 20, "trigger ignored with start bit");
        do_write(5'b01100, 6, n);
        wait_sig(1, 1'b1, SC + 40, n);
        trig_wait(10, n);
        chk_rng(n, 2, 6, "trigger enabled again");
        repeat (400) @(posedge clk_sys);
    endtask : t_soft

    task automatic t_standby();
        do_write(5'b10001, 6, n);
        chk_val(12'({chanSel, powerdownBit}), 12'h008, "standby needs seventh edge");
        do_write(5'b10001, 7, n);
        chk_val(12'(powerdownBit), 12'h001, "standby set");
        wait_sig(1, 1'b1, SC + 40, n);
        trig_wait(20, n);
        chk_rng(n, 20, 20, "no start in standby");
        do_write(5'b00000, 3, n);
        chk_val(12'({chanSel, powerdownBit}), 12'h009, "short write ignored");
        do_write(5'b00000, 7, n);
        chk_val(12'(powerdownBit), 12'h000, "standby cleared");
        wait_sig(1, 1'b1, SC + 40, n);
    endtask : t_standby

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    initial begin
        reset_n = 1'b0;
        selfClockMode = 1'b0;
        degradedRateEn = 1'b0;
        rawSampleCode = 12'h000;
        mclkDiv = 3'h0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_load();
        t_blocked();
        t_hw(12'h000);
        t_hw(12'hFFF);
        t_hw(12'h5A3);
        t_gap(1'b0, 1'b1, 2, 6);
        t_gap(1'b0, 1'b0, 10, 10);
        t_gap(1'b1, 1'b1, 10, 10);
        t_soft();
        t_standby();
        wrap_up();
    end
endmodule : test_adc_conversion_start_control
